// *** rtl/gcb_global_clock_gate_and_mux.sv ***
// sixteen global clock buffer cells with an AXI4-Lite configuration slave
`include "gcb_map.svh"
`default_nettype none
module gcb_global_clock_gate_and_mux (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [15:0] PAD_IN,
    input wire logic [15:0] MANAGER_IN,
    input wire logic [15:0] LOCAL_IN,
    input wire logic [15:0] SECOND_IN,
    input wire logic [15:0] ENABLE_IN,
    input wire logic [15:0] SELECT_IN,
    input wire logic MANAGER_INPUT_CLOCK,
    input wire logic MANAGER_LOCKED,
    output logic [15:0] GLOBAL_CLOCK_OUT,
    output logic [15:0] PAD_USER_OUT,
    output logic [15:0] PAD_USER_OE,
    output logic DOUBLED_CLOCK_OUT,
    output logic DOUBLED_CLOCK_INVERTED_OUT,
    output logic QUARTER_PHASE_OUT,
    output logic THREE_QUARTER_PHASE_OUT,
    input wire logic [31:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [31:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    // static configuration: mode/source per buffer (2+2 bits), falling, used
    logic [31:0] cfg_mode;
    logic [31:0] cfg_src;
    logic [15:0] cfg_falling;
    logic [15:0] cfg_used;
    logic [15:0] sel_reg;
    logic [15:0] en_reg;
    logic [15:0] pad_user_out;
    logic [15:0] pad_user_oe;
    logic mgr_hf;
    // pin inputs pass two flops before use
    logic [15:0] pad_s1, pad_s2, mgr_s1, mgr_s2, loc_s1, loc_s2, sec_s1, sec_s2;
    logic [15:0] ena_s1, ena_s2, sel_s1, sel_s2;
    logic mci_s1, mci_s2, lck_s1, lck_s2;
    logic [15:0] cell_out;
    logic [1:0] dbl_div;
    logic mci_prev;
    logic aw_held, w_held;
    logic [31:0] aw_addr, w_data;
    logic [3:0] w_strb;
    logic tick;
    logic [31:0] sel_word, en_word, mgr_word, pad_word;

    assign tick = 1'b1;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
        input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (strb[i])
                r[i*8 +: 8] = data[i*8 +: 8];
        return r;
    endfunction

    function automatic logic addr_hit(input logic [31:0] addr, input logic [31:0] base);
        return addr[7:2] == base[7:2] && addr[31:8] == 24'h00_0000;
    endfunction

    // merged words, so byte lanes land on the live halves of shared registers
    assign sel_word = merge({cfg_used, cfg_falling}, w_data, w_strb);
    assign en_word = merge({sel_reg, en_reg}, w_data, w_strb);
    assign mgr_word = merge({31'h0000_0000, mgr_hf}, w_data, w_strb);
    assign pad_word = merge({pad_user_oe, pad_user_out}, w_data, w_strb);

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            pad_s1 <= 16'h0000; pad_s2 <= 16'h0000; mgr_s1 <= 16'h0000; mgr_s2 <= 16'h0000;
            loc_s1 <= 16'h0000; loc_s2 <= 16'h0000; sec_s1 <= 16'h0000; sec_s2 <= 16'h0000;
            ena_s1 <= 16'h0000; ena_s2 <= 16'h0000; sel_s1 <= 16'h0000; sel_s2 <= 16'h0000;
            mci_s1 <= 1'b0; mci_s2 <= 1'b0; lck_s1 <= 1'b0; lck_s2 <= 1'b0;
        end
        else
        begin
            pad_s1 <= PAD_IN; pad_s2 <= pad_s1; mgr_s1 <= MANAGER_IN; mgr_s2 <= mgr_s1;
            loc_s1 <= LOCAL_IN; loc_s2 <= loc_s1; sec_s1 <= SECOND_IN; sec_s2 <= sec_s1;
            ena_s1 <= ENABLE_IN; ena_s2 <= ena_s1; sel_s1 <= SELECT_IN; sel_s2 <= sel_s1;
            mci_s1 <= MANAGER_INPUT_CLOCK; mci_s2 <= mci_s1;
            lck_s1 <= MANAGER_LOCKED; lck_s2 <= lck_s1;
        end
    end

    // write channel: address and data taken in either order
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            aw_held <= 1'b0; w_held <= 1'b0;
            aw_addr <= 32'h0000_0000; w_data <= 32'h0000_0000; w_strb <= 4'h0;
        end
        else
        begin
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_held <= 1'b1;
                aw_addr <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_held <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
            if (aw_held && w_held)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
        end
        else
        begin
            S_AXI_AWREADY <= !aw_held && !S_AXI_BVALID && !(S_AXI_AWVALID && S_AXI_AWREADY);
            S_AXI_WREADY <= !w_held && !S_AXI_BVALID && !(S_AXI_WVALID && S_AXI_WREADY);
        end
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            cfg_mode <= 32'h0000_0000;
            cfg_src <= 32'h0000_0000;
            cfg_falling <= 16'h0000;
            cfg_used <= 16'h0000;
            sel_reg <= 16'h0000;
            en_reg <= 16'hffff;
            mgr_hf <= 1'b0;
            pad_user_out <= 16'h0000;
            pad_user_oe <= 16'h0000;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `GCB_RESP_OKAY;
        end
        else
        begin
            if (S_AXI_BVALID && S_AXI_BREADY)
                S_AXI_BVALID <= 1'b0;
            if (aw_held && w_held)
            begin
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= `GCB_RESP_OKAY;
                if (addr_hit(aw_addr, `GCB_ADDR_CFG))
                    cfg_mode <= merge(cfg_mode, w_data, w_strb);
                else if (addr_hit(aw_addr, `GCB_ADDR_CFG2))
                    cfg_src <= merge(cfg_src, w_data, w_strb);
                else if (addr_hit(aw_addr, `GCB_ADDR_SEL))
                begin
                    cfg_falling <= sel_word[15:0];
                    cfg_used <= sel_word[31:16];
                end
                else if (addr_hit(aw_addr, `GCB_ADDR_EN))
                begin
                    en_reg <= en_word[15:0];
                    sel_reg <= en_word[31:16];
                end
                else if (addr_hit(aw_addr, `GCB_ADDR_MGR))
                    mgr_hf <= mgr_word[`GCB_MGR_HF_BIT];
                else if (addr_hit(aw_addr, `GCB_ADDR_PADIO))
                begin
                    pad_user_out <= pad_word[15:0];
                    pad_user_oe <= pad_word[31:16];
                end
                else if (!addr_hit(aw_addr, `GCB_ADDR_STAT) && !addr_hit(aw_addr, `GCB_ADDR_OUT))
                    S_AXI_BRESP <= `GCB_RESP_SLVERR;
            end
        end
    end

    // read channel, one-cycle turnaround
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0000_0000;
            S_AXI_RRESP <= `GCB_RESP_OKAY;
        end
        else
        begin
            S_AXI_ARREADY <= !S_AXI_RVALID && !S_AXI_ARREADY && S_AXI_ARVALID;
            if (S_AXI_RVALID && S_AXI_RREADY)
                S_AXI_RVALID <= 1'b0;
            if (S_AXI_ARVALID && S_AXI_ARREADY)
            begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= `GCB_RESP_OKAY;
                if (addr_hit(S_AXI_ARADDR, `GCB_ADDR_CFG))
                    S_AXI_RDATA <= cfg_mode;
                else if (addr_hit(S_AXI_ARADDR, `GCB_ADDR_CFG2))
                    S_AXI_RDATA <= cfg_src;
                else if (addr_hit(S_AXI_ARADDR, `GCB_ADDR_SEL))
                    S_AXI_RDATA <= {cfg_used, cfg_falling};
                else if (addr_hit(S_AXI_ARADDR, `GCB_ADDR_EN))
                    S_AXI_RDATA <= {sel_reg, en_reg};
                else if (addr_hit(S_AXI_ARADDR, `GCB_ADDR_STAT))
                    S_AXI_RDATA <= {16'h0000, pad_s2};
                else if (addr_hit(S_AXI_ARADDR, `GCB_ADDR_MGR))
                    S_AXI_RDATA <= {30'h0, lck_s2, mgr_hf};
                else if (addr_hit(S_AXI_ARADDR, `GCB_ADDR_OUT))
                    S_AXI_RDATA <= {16'h0000, GLOBAL_CLOCK_OUT};
                else if (addr_hit(S_AXI_ARADDR, `GCB_ADDR_PADIO))
                    S_AXI_RDATA <= {pad_user_oe, pad_user_out};
                else
                begin
                    S_AXI_RDATA <= 32'h0000_0000;
                    S_AXI_RRESP <= `GCB_RESP_SLVERR;
                end
            end
        end
    end

    // sixteen cells; a clock pad used as a source of a used buffer has its user output enable cleared
    generate
        for (genvar g = 0; g < `GCB_NUM_BUF; g++)
        begin : cells
            logic first_in;
            assign first_in = (cfg_src[2*g +: 2] == gcb_pkg::GCB_SRC_PAD) ? pad_s2[g] :
                (cfg_src[2*g +: 2] == gcb_pkg::GCB_SRC_MANAGER) ? mgr_s2[g] : loc_s2[g];
            gcb_buffer_cell u_cell (
                .clk(CLK),
                .reset(RESET),
                .tick(tick),
                .mode(gcb_pkg::gcb_mode_e'(cfg_mode[2*g +: 2])),
                .falling(cfg_falling[g]),
                .first_clock_in(first_in),
                .second_clock_in(sec_s2[g]),
                .enable(ena_s2[g] & en_reg[g]),
                .select(sel_s2[g] ^ sel_reg[g]),
                .clock_out(cell_out[g])
            );
        end
    endgenerate

    // unused branches held at their idle level instead of toggling
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
            GLOBAL_CLOCK_OUT <= 16'h0000;
        else
            GLOBAL_CLOCK_OUT <= (cell_out & cfg_used) | (cfg_falling & ~cfg_used);
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            PAD_USER_OUT <= 16'h0000;
            PAD_USER_OE <= 16'h0000;
        end
        else
        begin
            // a pad routed as clock source of a used buffer never drives
            for (int i = 0; i < `GCB_NUM_PAD; i++)
            begin
                PAD_USER_OUT[i] <= pad_user_out[i];
                PAD_USER_OE[i] <= pad_user_oe[i] &&
                    !(cfg_used[i] && cfg_src[2*i +: 2] == gcb_pkg::GCB_SRC_PAD);
            end
        end
    end

    // coarse synthesized clocks, low while mgr_hf is set: doubled pair divides CLK by two, 50/50 duty; phase pair follows the delayed manager input clock
    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            mci_prev <= 1'b0;
            dbl_div <= 2'h0;
        end
        else
        begin
            mci_prev <= mci_s2;
            dbl_div <= dbl_div + 2'h1;
        end
    end

    always_ff @(posedge CLK or posedge RESET)
    begin
        if (RESET)
        begin
            DOUBLED_CLOCK_OUT <= 1'b0;
            DOUBLED_CLOCK_INVERTED_OUT <= 1'b1;
            QUARTER_PHASE_OUT <= 1'b0;
            THREE_QUARTER_PHASE_OUT <= 1'b0;
        end
        else if (mgr_hf)
        begin
            DOUBLED_CLOCK_OUT <= 1'b0;
            DOUBLED_CLOCK_INVERTED_OUT <= 1'b0;
            QUARTER_PHASE_OUT <= 1'b0;
            THREE_QUARTER_PHASE_OUT <= 1'b0;
        end
        else
        begin
            DOUBLED_CLOCK_OUT <= dbl_div[0];
            DOUBLED_CLOCK_INVERTED_OUT <= ~dbl_div[0];
            QUARTER_PHASE_OUT <= mci_prev;
            THREE_QUARTER_PHASE_OUT <= ~mci_prev;
        end
    end

    AST_HF_SILENT: assert property (@(posedge CLK) disable iff (RESET)
        mgr_hf |=> !DOUBLED_CLOCK_OUT && !QUARTER_PHASE_OUT)
    else $error("doubled or quarter output active in high-frequency mode");
    AST_DOUBLED_INV: assert property (@(posedge CLK) disable iff (RESET)
        !mgr_hf ##1 !mgr_hf |-> DOUBLED_CLOCK_INVERTED_OUT == !DOUBLED_CLOCK_OUT)
    else $error("inverted doubled clock not complementary");
endmodule
`default_nettype wire

// *** include/gcb_map.svh ***
// register offsets, field positions and constants for the global clock buffer block
`ifndef GCB_MAP_SVH
`define GCB_MAP_SVH
`define GCB_NUM_BUF 16
`define GCB_NUM_PAD 16
`define GCB_QUAD_CLK 8
`define GCB_ADDR_CFG 32'h0000_0000
`define GCB_ADDR_CFG2 32'h0000_0004
`define GCB_ADDR_SEL 32'h0000_0008
`define GCB_ADDR_EN 32'h0000_000c
`define GCB_ADDR_STAT 32'h0000_0010
`define GCB_ADDR_MGR 32'h0000_0014
`define GCB_ADDR_OUT 32'h0000_0018
`define GCB_ADDR_PADIO 32'h0000_001c
`define GCB_MGR_HF_BIT 0
`define GCB_MGR_LOCK_BIT 1
`define GCB_RESP_OKAY 2'h0
`define GCB_RESP_SLVERR 2'h2
`endif

// *** include/gcb_pkg.sv ***
// types shared by the global clock buffer block
`default_nettype none
package gcb_pkg;
    typedef enum logic [1:0] {
        GCB_MODE_BUFFER = 2'h0,
        GCB_MODE_GATE = 2'h1,
        GCB_MODE_SELECT = 2'h3
    } gcb_mode_e;
    typedef enum logic [1:0] {
        GCB_SRC_PAD = 2'h0,
        GCB_SRC_MANAGER = 2'h1,
        GCB_SRC_LOCAL = 2'h3
    } gcb_src_e;
    // switchover sequence, gray along run, drain, park, wait, run
    typedef enum logic [1:0] {
        GCB_ST_RUN = 2'h0,
        GCB_ST_DRAIN = 2'h1,
        GCB_ST_PARK = 2'h3,
        GCB_ST_WAIT = 2'h2
    } gcb_state_e;
endpackage
`default_nettype wire

// *** rtl/gcb_buffer_cell.sv ***
// one global clock buffer cell: pass-through, gate or glitch-free selector
`include "gcb_map.svh"
`default_nettype none
module gcb_buffer_cell (
    input wire logic clk,
    input wire logic reset,
    input wire logic tick,
    input wire gcb_pkg::gcb_mode_e mode,
    input wire logic falling,
    input wire logic first_clock_in,
    input wire logic second_clock_in,
    input wire logic enable,
    input wire logic select,
    output logic clock_out
);
    // inputs are sampled clock levels; the falling variant works on inverted levels
    logic a;
    logic b;
    logic a_prev;
    logic b_prev;
    logic cur;
    logic cur_clk;
    logic gated;
    logic out_pos;
    logic next_out;
    gcb_pkg::gcb_state_e state;
    gcb_pkg::gcb_state_e next_state;

    assign a = first_clock_in ^ falling;
    assign b = second_clock_in ^ falling;
    assign cur_clk = cur ? b : a;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            a_prev <= 1'b0;
            b_prev <= 1'b0;
        end
        else if (tick)
        begin
            a_prev <= a;
            b_prev <= b;
        end
    end

    // gate decision latched on the rising edge only
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            gated <= 1'b0;
        else if (tick && a && !a_prev)
            gated <= enable;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            cur <= 1'b0;
        else if (tick && state == gcb_pkg::GCB_ST_WAIT && next_state == gcb_pkg::GCB_ST_RUN)
            cur <= ~cur;
    end

    always_comb
    begin
        next_state = state;
        case (state)
            gcb_pkg::GCB_ST_RUN:
                if (select != cur)
                    next_state = gcb_pkg::GCB_ST_DRAIN;
            gcb_pkg::GCB_ST_DRAIN:
                if (!(cur ? b : a))
                    next_state = gcb_pkg::GCB_ST_PARK;
            gcb_pkg::GCB_ST_PARK:
                next_state = gcb_pkg::GCB_ST_WAIT;
            gcb_pkg::GCB_ST_WAIT:
                if (cur ? (a_prev && !a) : (b_prev && !b))
                    next_state = gcb_pkg::GCB_ST_RUN;
            default:
                next_state = gcb_pkg::GCB_ST_RUN;
        endcase
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            state <= gcb_pkg::GCB_ST_RUN;
        else if (tick)
            state <= next_state;
    end

    always_comb
    begin
        next_out = 1'b0;
        case (mode)
            gcb_pkg::GCB_MODE_BUFFER:
                next_out = a;
            gcb_pkg::GCB_MODE_GATE:
                next_out = (a && !a_prev) ? (a && enable) : (a && gated);
            gcb_pkg::GCB_MODE_SELECT:
                // parked low between drain and the new clock's fall
                next_out = (state == gcb_pkg::GCB_ST_RUN || state == gcb_pkg::GCB_ST_DRAIN)
                    ? (cur ? b : a) : 1'b0;
            default:
                next_out = 1'b0;
        endcase
    end

    // out_pos idles low, so the falling variant rests high
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            out_pos <= 1'b0;
        else if (tick)
            out_pos <= next_out;
    end

    assign clock_out = out_pos ^ falling;

    AST_PARK_LOW: assert property (@(posedge clk) disable iff (reset)
        (tick && state == gcb_pkg::GCB_ST_WAIT && mode == gcb_pkg::GCB_MODE_SELECT)
        |=> !out_pos)
    else $error("selector output not low while waiting");
    AST_BLOCKED_LOW: assert property (@(posedge clk) disable iff (reset)
        (tick && mode == gcb_pkg::GCB_MODE_GATE && a && !a_prev && !enable)
        |=> !out_pos)
    else $error("blocked pulse reached output");
    AST_PASS_PULSE: assert property (@(posedge clk) disable iff (reset)
        (tick && mode == gcb_pkg::GCB_MODE_GATE && a && !a_prev && enable)
        |=> out_pos)
    else $error("enabled pulse not passed");
    AST_HOLD_DECISION: assert property (@(posedge clk) disable iff (reset)
        (tick && a && a_prev) |=> $stable(gated))
    else $error("gate decision changed during high");
    AST_NO_SWITCH_HIGH: assert property (@(posedge clk) disable iff (reset)
        (state == gcb_pkg::GCB_ST_DRAIN && (cur ? b : a)) |=> state != gcb_pkg::GCB_ST_PARK)
    else $error("switched while current clock high");
    AST_RUN_FOLLOWS: assert property (@(posedge clk) disable iff (reset)
        (tick && mode == gcb_pkg::GCB_MODE_SELECT && state == gcb_pkg::GCB_ST_RUN && select == cur)
        |=> out_pos == $past(cur_clk))
    else $error("selector does not follow chosen clock");
endmodule
`default_nettype wire

// *** tb/gcb_clock_sources.sv ***
// free-running slow clock sources for the pad, manager, interconnect and second inputs
`default_nettype none
module gcb_clock_sources (
    input wire logic clk,
    output logic [63:0] wave,
    output logic mgr_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt [65];
    initial
    begin
        wave = '0;
        mgr_clk = 1'b0;
        foreach (cnt[j]) cnt[j] = 0;
    end
    // lanes within a group of sixteen have distinct half periods, far below the sampling rate of the block
    always @(posedge clk)
    begin
        for (int j = 0; j < 65; j++)
        begin
            cnt[j] <= cnt[j] + 1;
            if (cnt[j] >= (j == 64 ? 15 : 7 + j % 16 + 2 * (j / 16)))
            begin
                cnt[j] <= 0;
                if (j == 64) mgr_clk <= ~mgr_clk;
                else wave[j] <= ~wave[j];
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/test_gcb_global_clock_gate_and_mux.sv ***
// self-checking bench for the global clock buffer block
`default_nettype none
module test_gcb_global_clock_gate_and_mux;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0;
    logic rst = 1'b1;
    logic [15:0] en = '0, sel = '0, gout, pout, poe;
    logic [31:0] awa = '0, wd = '0, ara = '0, rdata, d;
    logic awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic awr, wr, bv, arr, rv, dbl, dbln, qtr, tqp, mclk, in_bit;
    logic q_in = 0, p_in = 0, p_out = 0, seen = 0, grand = 0, srand = 0, sel_fix = 0;
    logic [1:0] bresp, rresp;
    logic [3:0] p_mgr = '0;
    logic [63:0] wave;
    int srcsel = 0, n_mismatch = 0, compares = 0, n_in, n_out, n_exp, n_low, n_tog, run, min_run;
    gcb_clock_sources gcb_clock_sources_i (.clk(CLK), .wave(wave), .mgr_clk(mclk));
    gcb_global_clock_gate_and_mux gcb_global_clock_gate_and_mux_i (.CLK(CLK), .RESET(rst),
        .PAD_IN(wave[15:0]), .MANAGER_IN(wave[31:16]), .LOCAL_IN(wave[47:32]),
        .SECOND_IN(wave[63:48]), .ENABLE_IN(en), .SELECT_IN(sel), .MANAGER_INPUT_CLOCK(mclk),
        .MANAGER_LOCKED(1'b1), .GLOBAL_CLOCK_OUT(gout), .PAD_USER_OUT(pout), .PAD_USER_OE(poe),
        .DOUBLED_CLOCK_OUT(dbl), .DOUBLED_CLOCK_INVERTED_OUT(dbln), .QUARTER_PHASE_OUT(qtr),
        .THREE_QUARTER_PHASE_OUT(tqp), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
        .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wv),
        .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
        .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry));
    always #5 CLK = ~CLK;
    assign in_bit = wave[sel[0] ? 48 : 16 * srcsel];
    // outputs settle by the falling edge, so the model samples there
    always @(negedge CLK)
    begin
        if (in_bit && !p_in)
        begin
            n_in++;
            if (en[0]) n_exp++;
        end
        if (gout[0] && !p_out) n_out++;
        if (!gout[0]) n_low++;
        if ({dbl, dbln, qtr, tqp} != p_mgr) n_tog++;
        if (gout[0] != p_out)
        begin
            if (seen && run < min_run) min_run = run;
            seen = 1;
            run = 1;
        end
        else run++;
        p_in = in_bit;
        p_out = gout[0];
        p_mgr = {dbl, dbln, qtr, tqp};
    end
    // levels change only right after an input edge, well clear of the setup window
    always @(posedge CLK)
    begin
        q_in <= in_bit;
        // a change just after a rise lands in the high time and must not count
        if (!grand) en[0] <= 1'b0;
        else if (q_in != in_bit) en[0] <= 1'($urandom % 2);
        if (!q_in && in_bit && !srand) sel[0] <= sel_fix;
        else if (!q_in && in_bit && $urandom % 3 == 0) sel[0] <= ~sel[0];
    end
    task stop_test;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task cmp_val(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // edge counts may differ by one where a pulse straddles the window border
    task cmp_cnt(input int got, input int exp);
        cmp_val(32'(((got - exp) ** 2 <= 1) ? exp : got), 32'(exp));
    endtask
    task tmo(input int k);
        if (k == 50)
        begin
            $display("timeout t=%0t", $time);
            n_mismatch++;
            stop_test;
        end
    endtask
    task wr_reg(input logic [31:0] a, input logic [31:0] v);
        int k;
        awa <= a;
        wd <= v;
        awv <= 1;
        wv <= 1;
        bry <= 1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge CLK);
            if (bv === 1'b1) break;
            if (awr === 1'b1) awv <= 0;
            if (wr === 1'b1) wv <= 0;
        end
        tmo(k);
        cmp_val(bresp, 2'h0);
        bry <= 0;
        @(posedge CLK);
    endtask
    task rd_chk(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
        int k;
        ara <= a;
        arv <= 1;
        rry <= 1;
        for (k = 0; k < 50; k++)
        begin
            @(posedge CLK);
            if (rv === 1'b1) break;
            if (arr === 1'b1) arv <= 0;
        end
        tmo(k);
        cmp_val(rdata, ed);
        cmp_val(rresp, er);
        rry <= 0;
        @(posedge CLK);
    endtask
    task window(input int n);
        repeat (20) @(posedge CLK);
        n_in = 0;
        n_out = 0;
        n_exp = 0;
        n_low = 0;
        n_tog = 0;
        seen = 0;
        min_run = 999;
        repeat (n) @(posedge CLK);
    endtask
    initial
    begin
        void'($urandom(32'h5c45233f));
        repeat (2) @(posedge CLK);
        cmp_val(gout, 32'h0);
        cmp_val(dbln, 32'h1);
        rst <= 0;
        @(posedge CLK);
        rd_chk(32'h0c, 32'h0000ffff, 2'h0);
        rd_chk(32'h00, 32'h0, 2'h0);
        rd_chk(32'h40, 32'h0, 2'h2);
        d = $urandom;
        wr_reg(32'h1c, d);
        repeat (3) @(posedge CLK);
        cmp_val({poe, pout}, d);
        rd_chk(32'h1c, d, 2'h0);
        $display("test registers done");
        wr_reg(32'h08, 32'hffff0000);
        for (int s = 0; s < 3; s++)
        begin
            wr_reg(32'h04, {16{s == 2 ? 2'h3 : 2'(s)}});
            srcsel = s;
            window(400);
            cmp_cnt(n_out, n_in);
            cmp_val(poe, s == 0 ? 32'h0 : 32'(d[31:16]));
        end
        wr_reg(32'h08, 32'hfffe0000);
        window(300);
        cmp_val(n_out, 32'h0);
        $display("test buffer done");
        wr_reg(32'h08, 32'hffff0000);
        wr_reg(32'h04, 32'h0);
        srcsel = 0;
        wr_reg(32'h00, 32'h55555555);
        grand = 1;
        window(1500);
        cmp_cnt(n_out, n_exp);
        grand = 0;
        window(300);
        cmp_val(n_out, 32'h0);
        wr_reg(32'h08, 32'hffff0001);
        window(300);
        cmp_val(n_low, 32'h0);
        wr_reg(32'h08, 32'hffff0000);
        $display("test gate done");
        wr_reg(32'h00, 32'hffffffff);
        window(400);
        cmp_cnt(n_out, n_in);
        sel_fix <= 1'b1;
        // the switchover waits for a rise, a drain and the new clock's fall
        repeat (60) @(posedge CLK);
        window(400);
        cmp_cnt(n_out, n_in);
        srand = 1;
        window(3000);
        srand = 0;
        cmp_val(min_run >= 8, 32'h1);
        $display("test selector done");
        wr_reg(32'h14, 32'h0);
        window(300);
        cmp_val(n_tog > 0, 32'h1);
        wr_reg(32'h14, 32'h1);
        window(300);
        cmp_val(n_tog, 32'h0);
        rd_chk(32'h14, 32'h3, 2'h0);
        $display("test manager done");
        stop_test;
    end
endmodule
`default_nettype wire
